// *** hc_pkg.sv ***
// constants, types and states for the extended hub command link
package hc_pkg;
  localparam int          HC_NPORT        = 5;
  localparam int          HC_BUF_BYTES    = 132;
  localparam logic [7:0]  HC_BUF_LIMIT    = 8'h84;
  localparam logic [7:0]  HC_MAX_COUNT    = 8'h20;
  localparam logic [7:0]  HC_MAX_BLOCK    = 8'h80;
  localparam int          HC_OFF_CMD      = 0;
  localparam int          HC_OFF_STAT     = 1;
  localparam int          HC_OFF_D1       = 2;
  localparam int          HC_OFF_D2       = 3;
  localparam logic [7:0]  HC_OFF_D2_B     = 8'h03;
  localparam logic [7:0]  HC_OFF_D3_B     = 8'h04;
  localparam logic [7:0]  HC_TRIG_HI      = 8'h99;
  localparam logic [7:0]  HC_TRIG_LO      = 8'h3E;
  localparam logic [7:0]  HC_TRIG_END     = 8'h00;
  localparam logic [5:0]  HC_ADDR_BASE    = 6'h16;
  localparam logic [6:0]  HC_DEFAULT_ADDR = 7'h2D;
  localparam int          HC_ADDR_DEF_BIT = 7;
  localparam int          HC_KILL_APPLY   = 7;
  localparam logic [7:0]  HC_CMD_SETADDR  = 8'h00;
  localparam logic [7:0]  HC_CMD_GETDEF   = 8'h01;
  localparam logic [7:0]  HC_CMD_HUBINFO  = 8'h02;
  localparam logic [7:0]  HC_CMD_CHGMASK  = 8'h03;
  localparam logic [7:0]  HC_CMD_CONNECT  = 8'h80;
  localparam logic [7:0]  HC_CMD_POWER    = 8'h81;
  localparam logic [7:0]  HC_CMD_KILL     = 8'h82;
  localparam logic [7:0]  HC_CMD_LINES    = 8'h83;
  localparam logic [7:0]  HC_CMD_CHGRD    = 8'h84;
  localparam logic [7:0]  HC_CMD_CHGWR    = 8'h85;
  localparam logic [7:0]  HC_CMD_CHGBLK   = 8'h86;
  localparam logic [7:0]  HC_STAT_OK      = 8'h01;
  localparam logic [7:0]  HC_STAT_BAD     = 8'h80;
  localparam logic [1:0]  HC_REG_OP       = 2'h0;
  localparam logic [1:0]  HC_REG_STATUS   = 2'h1;
  localparam logic [1:0]  HC_OP_WRITE     = 2'h0;
  localparam logic [1:0]  HC_OP_READ      = 2'h1;
  localparam logic [1:0]  HC_OP_START     = 2'h2;
  localparam logic [1:0]  HC_OP_STOP      = 2'h3;
  localparam int          HC_OP_LSB       = 8;

  typedef enum logic [4:0] {
    EX_IDLE   = 5'b00001,
    EX_DECODE = 5'b00010,
    EX_ISSUE  = 5'b00100,
    EX_WAIT   = 5'b01000,
    EX_FINISH = 5'b10000
  } hc_exec_type;

  typedef enum logic [3:0] {
    H_IDLE   = 4'b0001,
    H_WAIT   = 4'b0010,
    H_ISSUE  = 4'b0100,
    H_ANSWER = 4'b1000
  } hc_host_type;
endpackage : hc_pkg

// *** hc_link_if.sv ***
// byte-level transaction link between host end and hub end
`timescale 1ns/10ps
`default_nettype none
interface hc_link_if;
  logic       hStart;
  logic       hWrite;
  logic       hRead;
  logic       hStop;
  logic [7:0] hData;
  logic       dDone;
  logic       dAck;
  logic [7:0] dData;
  logic       dBusy;

  modport dev  (input hStart, hWrite, hRead, hStop, hData, output dDone, dAck, dData, dBusy);
  modport host (output hStart, hWrite, hRead, hStop, hData, input dDone, dAck, dData, dBusy);
endinterface : hc_link_if
`default_nettype wire

// *** hc_dev.sv ***
// hub end: buffer, trigger decode and extended command execution
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module hc_dev (
  // clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        rst_n,
  // link
  hc_link_if.dev                           link,
  // address strap and hub state
  input  wire logic                        addrStrap,
  input  wire logic                        hubConfigured,
  input  wire logic [6:0]                  legacyHubDeviceNumber,
  input  wire logic [7:0]                  chargerPortMask,
  // per-port status
  input  wire logic [hc_pkg::HC_NPORT-1:0] legacyPortSleeping,
  input  wire logic [hc_pkg::HC_NPORT-1:0] superspeedPortSleeping,
  input  wire logic [hc_pkg::HC_NPORT-1:0] legacyAttachSeen,
  input  wire logic [hc_pkg::HC_NPORT-1:0] superspeedAttachSeen,
  input  wire logic [hc_pkg::HC_NPORT-1:0] portPowerOn,
  input  wire logic [hc_pkg::HC_NPORT-1:0] minusLineHigh,
  input  wire logic [hc_pkg::HC_NPORT-1:0] plusLineHigh,
  // per-port kill controls
  output logic      [hc_pkg::HC_NPORT-1:0] portPowerForcedOff,
  output logic      [hc_pkg::HC_NPORT-1:0] superspeedTerminationOff,
  output logic      [hc_pkg::HC_NPORT-1:0] legacyTerminationOff,
  // charger controller access
  output logic                             chargerReq,
  output logic                             chargerWrite,
  output logic      [7:0]                  chargerAddr,
  output logic      [7:0]                  chargerWdata,
  input  wire logic                        chargerAck,
  input  wire logic [7:0]                  chargerRdata
);
  import hc_pkg::*;

  logic [7:0]  buffer [HC_BUF_BYTES];
  logic [2:0]  byteIdx;
  logic        addressed;
  logic        isRead;
  logic        trig;
  logic [7:0]  offHi;
  logic [7:0]  ptr;
  logic [7:0]  remain;
  logic [6:0]  slaveAddr;
  logic        strapDone;
  hc_exec_type exState;
  logic [7:0]  chgCnt;
  logic [7:0]  chgDst;
  logic [2:0]  curIdx;
  logic        curAddr;
  logic        next_ack;
  logic        hostStore;
  logic        launch;
  logic        rdOk;
  logic [7:0]  cmd;

  function automatic logic [7:0] portResult(input logic [7:0] c, input int p);
    logic [7:0] r;
    r = 8'h00;
    case (c)
      HC_CMD_CONNECT: r = {2'b00, legacyPortSleeping[p], superspeedPortSleeping[p],
                           2'b00, legacyAttachSeen[p], superspeedAttachSeen[p]};
      HC_CMD_POWER:   r = {7'h00, portPowerOn[p]};
      HC_CMD_LINES:   r = {6'h00, minusLineHigh[p], plusLineHigh[p]};
      default:        r = 8'h00;
    endcase
    return r;
  endfunction : portResult

  function automatic logic cmdKnown(input logic [7:0] c);
    return (c inside {HC_CMD_SETADDR, HC_CMD_GETDEF, HC_CMD_HUBINFO, HC_CMD_CHGMASK,
                      HC_CMD_CONNECT, HC_CMD_POWER, HC_CMD_KILL, HC_CMD_LINES,
                      HC_CMD_CHGRD, HC_CMD_CHGWR, HC_CMD_CHGBLK});
  endfunction : cmdKnown

  assign cmd = buffer[HC_OFF_CMD];

  // a start in the same cycle as a byte makes that byte the address byte
  always_comb begin
    curIdx    = link.hStart ? 3'd0 : byteIdx;
    curAddr   = link.hStart ? 1'b0 : addressed;
    next_ack  = 1'b0;
    hostStore = 1'b0;
    launch    = 1'b0;
    rdOk      = curAddr && isRead && !link.dBusy;
    if (link.hWrite && !link.dBusy) begin
      case (curIdx)
        3'd0: next_ack = (link.hData[7:1] == slaveAddr);
        3'd1,
        3'd2: next_ack = curAddr && !isRead;
        3'd3: begin
          if (trig) begin
            next_ack = curAddr && (link.hData == HC_TRIG_END);
            launch   = next_ack;
          end else begin
            next_ack = curAddr && !isRead && (link.hData != 8'h00)
                       && (link.hData <= HC_MAX_COUNT);
          end
        end
        default: begin
          next_ack  = curAddr && !isRead && !trig && (remain != 8'h00) && (ptr < HC_BUF_LIMIT);
          hostStore = next_ack;
        end
      endcase
    end
  end

  // transaction tracking and link answers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      byteIdx   <= 3'd0;
      addressed <= 1'b0;
      isRead    <= 1'b0;
      trig      <= 1'b0;
      offHi     <= 8'h00;
      ptr       <= 8'h00;
      remain    <= 8'h00;
      link.dDone <= 1'b0;
      link.dAck  <= 1'b0;
      link.dData <= 8'h00;
    end else begin
      link.dDone <= 1'b0;
      if (link.hStart || link.hStop) begin
        byteIdx   <= 3'd0;
        addressed <= 1'b0;
        trig      <= 1'b0;
      end
      if (link.hWrite) begin
        link.dDone <= 1'b1;
        link.dAck  <= next_ack;
        if (!link.dBusy) begin
          if (curIdx != 3'd4) byteIdx <= curIdx + 3'd1;
          case (curIdx)
            3'd0: begin
              addressed <= next_ack;
              isRead    <= link.hData[0];
            end
            3'd1: offHi <= link.hData;
            3'd2: begin
              // a refused transaction must not move the pointer
              if (next_ack) ptr <= link.hData;
              trig <= (offHi == HC_TRIG_HI) && (link.hData == HC_TRIG_LO);
            end
            // a refused count leaves nothing to store after it
            3'd3: remain <= next_ack ? link.hData : 8'h00;
            default: begin
              if (hostStore) begin
                ptr    <= ptr + 8'h01;
                remain <= remain - 8'h01;
              end
            end
          endcase
        end
      end
      if (link.hRead) begin
        link.dDone <= 1'b1;
        link.dAck  <= rdOk;
        // past the last result byte reads give zero
        link.dData <= (rdOk && ptr < HC_BUF_LIMIT) ? buffer[ptr] : 8'h00;
        if (rdOk && ptr < HC_BUF_LIMIT) ptr <= ptr + 8'h01;
      end
    end
  end

  // slave address: strap caught after release, then command 00h
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      slaveAddr <= HC_DEFAULT_ADDR;
      strapDone <= 1'b0;
    end else if (!strapDone) begin
      slaveAddr <= {HC_ADDR_BASE, addrStrap};
      strapDone <= 1'b1;
    end else if (exState == EX_DECODE && cmd == HC_CMD_SETADDR) begin
      if (buffer[HC_OFF_D1][HC_ADDR_DEF_BIT]) begin
        slaveAddr <= {HC_ADDR_BASE, addrStrap};
      end else begin
        slaveAddr <= buffer[HC_OFF_D1][6:0];
      end
    end
  end

  // execution sequencer and charger controller access
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      exState      <= EX_IDLE;
      link.dBusy   <= 1'b0;
      chargerReq   <= 1'b0;
      chargerWrite <= 1'b0;
      chargerAddr  <= 8'h00;
      chargerWdata <= 8'h00;
      chgCnt       <= 8'h00;
      chgDst       <= 8'h00;
    end else begin
      chargerReq <= 1'b0;
      case (exState)
        EX_IDLE: begin
          if (launch) begin
            exState    <= EX_DECODE;
            link.dBusy <= 1'b1;
          end
        end
        EX_DECODE: begin
          chargerAddr  <= buffer[HC_OFF_D1];
          chargerWdata <= buffer[HC_OFF_D2];
          chargerWrite <= (cmd == HC_CMD_CHGWR);
          chgDst       <= (cmd == HC_CMD_CHGBLK) ? HC_OFF_D3_B : HC_OFF_D2_B;
          case (cmd)
            HC_CMD_CHGRD,
            HC_CMD_CHGWR: begin
              chgCnt  <= 8'h01;
              exState <= EX_ISSUE;
            end
            HC_CMD_CHGBLK: begin
              // capped so results stay inside the buffer
              chgCnt  <= (buffer[HC_OFF_D2] > HC_MAX_BLOCK) ? HC_MAX_BLOCK
                                                            : buffer[HC_OFF_D2];
              exState <= (buffer[HC_OFF_D2] == 8'h00) ? EX_FINISH : EX_ISSUE;
            end
            default: exState <= EX_FINISH;
          endcase
        end
        EX_ISSUE: begin
          chargerReq <= 1'b1;
          exState    <= EX_WAIT;
        end
        EX_WAIT: begin
          if (chargerAck) begin
            chargerAddr <= chargerAddr + 8'h01;
            chgDst      <= chgDst + 8'h01;
            chgCnt      <= chgCnt - 8'h01;
            exState     <= (chgCnt == 8'h01) ? EX_FINISH : EX_ISSUE;
          end
        end
        EX_FINISH: begin
          exState    <= EX_IDLE;
          link.dBusy <= 1'b0;
        end
        default: begin
          exState    <= EX_IDLE;
          link.dBusy <= 1'b0;
        end
      endcase
    end
  end

  // buffer storage: host bytes, command results, status
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < HC_BUF_BYTES; i++) buffer[i] <= 8'h00;
    end else begin
      if (hostStore) buffer[ptr] <= link.hData;
      if (exState == EX_DECODE) begin
        case (cmd)
          HC_CMD_GETDEF:  buffer[HC_OFF_D1] <= {1'b0, HC_DEFAULT_ADDR};
          HC_CMD_HUBINFO: buffer[HC_OFF_D1] <= {hubConfigured, legacyHubDeviceNumber};
          HC_CMD_CHGMASK: buffer[HC_OFF_D1] <= chargerPortMask;
          HC_CMD_CONNECT,
          HC_CMD_POWER,
          HC_CMD_LINES: begin
            for (int p = 0; p < HC_NPORT; p++) begin
              if (buffer[HC_OFF_D1][p]) buffer[HC_OFF_D2 + p] <= portResult(cmd, p);
            end
          end
          default: ;
        endcase
      end
      if (exState == EX_WAIT && chargerAck && !chargerWrite && chgDst < HC_BUF_LIMIT) begin
        buffer[chgDst] <= chargerRdata;
      end
      if (exState == EX_FINISH) begin
        buffer[HC_OFF_STAT] <= cmdKnown(cmd) ? HC_STAT_OK : HC_STAT_BAD;
      end
    end
  end

  // kill controls, applied per masked port
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      portPowerForcedOff       <= '0;
      superspeedTerminationOff <= '0;
      legacyTerminationOff     <= '0;
    end else if (exState == EX_DECODE && cmd == HC_CMD_KILL) begin
      for (int p = 0; p < HC_NPORT; p++) begin
        if (buffer[HC_OFF_D1][p] && buffer[HC_OFF_D2 + p][HC_KILL_APPLY]) begin
          portPowerForcedOff[p]       <= buffer[HC_OFF_D2 + p][2];
          superspeedTerminationOff[p] <= buffer[HC_OFF_D2 + p][1];
          legacyTerminationOff[p]     <= buffer[HC_OFF_D2 + p][0];
        end
      end
    end
  end
endmodule : hc_dev
`default_nettype wire

// *** hc_host.sv ***
// host end: one link operation per software order
`timescale 1ns/10ps
`default_nettype none
module hc_host (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // software port
  input  wire logic [1:0]  regAddr,
  input  wire logic [15:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [15:0] regRdata,
  // link
  hc_link_if.host          link
);
  import hc_pkg::*;

  hc_host_type hState;
  logic [1:0]  op;
  logic [7:0]  txByte;
  logic [7:0]  rxByte;
  logic        ackSeen;

  // orders arriving while busy are dropped; software polls the busy bit
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hState      <= H_IDLE;
      op          <= HC_OP_WRITE;
      txByte      <= 8'h00;
      rxByte      <= 8'h00;
      ackSeen     <= 1'b0;
      link.hStart <= 1'b0;
      link.hWrite <= 1'b0;
      link.hRead  <= 1'b0;
      link.hStop  <= 1'b0;
      link.hData  <= 8'h00;
    end else begin
      link.hStart <= 1'b0;
      link.hWrite <= 1'b0;
      link.hRead  <= 1'b0;
      link.hStop  <= 1'b0;
      case (hState)
        H_IDLE: begin
          if (regWr && regAddr == HC_REG_OP) begin
            op     <= regWdata[HC_OP_LSB +: 2];
            txByte <= regWdata[7:0];
            hState <= H_WAIT;
          end
        end
        H_WAIT: begin
          // no strobe while the hub executes a command
          if (!link.dBusy) begin
            link.hStart <= (op == HC_OP_START);
            link.hWrite <= (op == HC_OP_START) || (op == HC_OP_WRITE);
            link.hRead  <= (op == HC_OP_READ);
            link.hStop  <= (op == HC_OP_STOP);
            link.hData  <= txByte;
            hState      <= H_ISSUE;
          end
        end
        H_ISSUE: hState <= (op == HC_OP_STOP) ? H_IDLE : H_ANSWER;
        H_ANSWER: begin
          if (link.dDone) begin
            ackSeen <= link.dAck;
            rxByte  <= link.dData;
            hState  <= H_IDLE;
          end
        end
        default: hState <= H_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= 16'h0000;
    end else if (regRd && regAddr == HC_REG_STATUS) begin
      regRdata <= {6'h00, (hState != H_IDLE), ackSeen, rxByte};
    end else begin
      regRdata <= 16'h0000;
    end
  end
endmodule : hc_host
`default_nettype wire

// *** hc_link_assertions.sv ***
// link checker between host end and hub end
`timescale 1ns/10ps
`default_nettype none
module hc_link_assertions (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       rst_n,
  // link
  input wire logic       hStart,
  input wire logic       hWrite,
  input wire logic       hRead,
  input wire logic       hStop,
  input wire logic [7:0] hData,
  input wire logic       dDone,
  input wire logic       dAck,
  input wire logic [7:0] dData,
  input wire logic       dBusy
);
  import hc_pkg::*;
  logic [2:0] idx;
  logic [7:0] firstByte;
  logic [7:0] secondByte;
  logic       allAcked;
  logic       readMode;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // byte position in the current transaction, saturating
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      idx <= 3'h0;
    end else if (hStart && hWrite) begin
      idx <= 3'h1;
    end else if (hStop) begin
      idx <= 3'h0;
    end else if (hWrite && idx != 3'h7) begin
      idx <= idx + 3'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      firstByte  <= 8'h00;
      secondByte <= 8'h00;
    end else if (hWrite && !hStart && idx == 3'h1) begin
      firstByte <= hData;
    end else if (hWrite && !hStart && idx == 3'h2) begin
      secondByte <= hData;
    end
  end

  // one refusal disarms the trigger check for the transaction
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      allAcked <= 1'b0;
      readMode <= 1'b0;
    end else if (hStart && hWrite) begin
      allAcked <= 1'b1;
      readMode <= hData[0];
    end else if (dDone && !dAck) begin
      allAcked <= 1'b0;
    end
  end

  sequence s_trigger_end;
    hWrite && !hStart && !dBusy && !readMode && allAcked && idx == 3'h3 &&
      firstByte == HC_TRIG_HI && secondByte == HC_TRIG_LO && hData == HC_TRIG_END;
  endsequence
  sequence s_exec_start;
    dDone && dAck && dBusy;
  endsequence

  a_answer_next: assert property ((hWrite || hRead) |=> dDone)
    else $error("byte not answered in next cycle");
  a_answer_cause: assert property (dDone |-> $past(hWrite || hRead))
    else $error("answer without request");
  a_answer_holds: assert property (!dDone |-> $stable(dAck) && $stable(dData))
    else $error("answer changed between answers");
  a_trigger_runs: assert property (s_trigger_end |=> s_exec_start)
    else $error("trigger did not start execution");
  a_busy_cause: assert property ($rose(dBusy) |-> dDone && dAck && $past(hWrite))
    else $error("busy rose without accepted byte");
  a_busy_bounded: assert property ($rose(dBusy) |-> ##[1:1000] !dBusy)
    else $error("execution did not finish");
  a_count_refused: assert property (hWrite && !hStart && idx == 3'h3 && !readMode &&
    firstByte != HC_TRIG_HI && (hData == 8'h00 || hData > HC_MAX_COUNT) |=> dDone && !dAck)
    else $error("bad byte count accepted");
  a_read_refused: assert property (hRead && !readMode && idx != 3'h0 |=>
    !dAck && dData == 8'h00)
    else $error("read in write transaction accepted");
endmodule : hc_link_assertions
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench: host end and hub end joined by the link
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import hc_pkg::*;
  logic                clk_sys = 1'b0;
  logic                rst_n = 1'b0;
  logic [1:0]          regAddr = 2'h0;
  logic [15:0]         regWdata = 16'h0000;
  logic                regWr = 1'b0;
  logic                regRd = 1'b0;
  logic [15:0]         regRdata;
  logic                addrStrap = 1'b1;
  logic                hubConfigured = 1'b1;
  logic [6:0]          legacyHubDeviceNumber = 7'h35;
  logic [7:0]          chargerPortMask = 8'h0A;
  logic [HC_NPORT-1:0] legacyPortSleeping = 5'h05;
  logic [HC_NPORT-1:0] superspeedPortSleeping = 5'h12;
  logic [HC_NPORT-1:0] legacyAttachSeen = 5'h0B;
  logic [HC_NPORT-1:0] superspeedAttachSeen = 5'h19;
  logic [HC_NPORT-1:0] portPowerOn = 5'h17;
  logic [HC_NPORT-1:0] minusLineHigh = 5'h06;
  logic [HC_NPORT-1:0] plusLineHigh = 5'h0C;
  logic [HC_NPORT-1:0] portPowerForcedOff;
  logic [HC_NPORT-1:0] superspeedTerminationOff;
  logic [HC_NPORT-1:0] legacyTerminationOff;
  logic                chargerReq;
  logic                chargerWrite;
  logic [7:0]          chargerAddr;
  logic [7:0]          chargerWdata;
  logic                chargerAck = 1'b0;
  logic [7:0]          chargerRdata = 8'h00;
  logic [15:0]         lastWrite = 16'h0000;
  logic [6:0]          addr = HC_DEFAULT_ADDR;
  logic [7:0]          rx;
  logic                ack;
  logic [7:0]          got[$];
  int                  mismatches = 0;
  int                  checkCount = 0;
  int                  cycles = 0;

  hc_link_if u_hc_link_if ();
  hc_host u_hc_host (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .link(u_hc_link_if));
  hc_dev u_hc_dev (.clk_sys(clk_sys), .rst_n(rst_n), .link(u_hc_link_if), .addrStrap(addrStrap),
    .hubConfigured(hubConfigured), .legacyHubDeviceNumber(legacyHubDeviceNumber),
    .chargerPortMask(chargerPortMask), .legacyPortSleeping(legacyPortSleeping),
    .superspeedPortSleeping(superspeedPortSleeping), .legacyAttachSeen(legacyAttachSeen),
    .superspeedAttachSeen(superspeedAttachSeen), .portPowerOn(portPowerOn),
    .minusLineHigh(minusLineHigh), .plusLineHigh(plusLineHigh),
    .portPowerForcedOff(portPowerForcedOff), .superspeedTerminationOff(superspeedTerminationOff),
    .legacyTerminationOff(legacyTerminationOff), .chargerReq(chargerReq),
    .chargerWrite(chargerWrite), .chargerAddr(chargerAddr), .chargerWdata(chargerWdata),
    .chargerAck(chargerAck), .chargerRdata(chargerRdata));
  hc_link_assertions u_hc_link_assertions (.clk_sys(clk_sys), .rst_n(rst_n),
    .hStart(u_hc_link_if.hStart), .hWrite(u_hc_link_if.hWrite), .hRead(u_hc_link_if.hRead),
    .hStop(u_hc_link_if.hStop), .hData(u_hc_link_if.hData), .dDone(u_hc_link_if.dDone),
    .dAck(u_hc_link_if.dAck), .dData(u_hc_link_if.dData), .dBusy(u_hc_link_if.dBusy));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  // charger controller stand-in: answers one cycle after each request
  always @(posedge clk_sys) begin
    chargerAck <= chargerReq;
    chargerRdata <= chargerAddr ^ 8'h5A;
    if (chargerReq && chargerWrite) begin
      lastWrite <= {chargerAddr, chargerWdata};
    end
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checkCount++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // one order, then poll status until the host end is idle again
  task automatic op(input logic [1:0] code, input logic [7:0] b);
    int i;
    @(posedge clk_sys);
    regAddr <= HC_REG_OP;
    regWdata <= {6'h00, code, b};
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
    regAddr <= HC_REG_STATUS;
    i = 0;
    do begin
      @(posedge clk_sys);
      regRd <= 1'b1;
      @(posedge clk_sys);
      regRd <= 1'b0;
      #1;
      i++;
    end while (regRdata[9] !== 1'b0 && i < 2000);
    rx = regRdata[7:0];
    ack = regRdata[8];
  endtask : op

  task automatic frame(input logic [7:0] b[$]);
    op(HC_OP_START, {addr, 1'b0});
    chk("addr ack", ack, 1'b1);
    foreach (b[k]) begin
      op(HC_OP_WRITE, b[k]);
      chk("byte ack", ack, 1'b1);
    end
    op(HC_OP_STOP, 8'h00);
  endtask : frame

  task automatic run(input logic [7:0] b[$]);
    frame({8'h00, 8'h00, 8'(b.size()), b});
    frame({HC_TRIG_HI, HC_TRIG_LO, HC_TRIG_END});
  endtask : run

  // offset set by a write, then repeated start in read direction
  task automatic fetch(input logic [7:0] off, input int n);
    op(HC_OP_START, {addr, 1'b0});
    op(HC_OP_WRITE, 8'h00);
    op(HC_OP_WRITE, off);
    op(HC_OP_START, {addr, 1'b1});
    got.delete();
    repeat (n) begin
      op(HC_OP_READ, 8'h00);
      got.push_back(rx);
    end
    op(HC_OP_STOP, 8'h00);
  endtask : fetch

  task automatic test_ports();
    logic [7:0] cmds[3] = '{HC_CMD_CONNECT, HC_CMD_POWER, HC_CMD_LINES};
    logic [7:0] e;
    foreach (cmds[c]) begin
      run({cmds[c], 8'h00, 8'h1F});
      fetch(8'h01, 7);
      chk("port status", got[0], HC_STAT_OK);
      for (int p = 0; p < HC_NPORT; p++) begin
        case (c)
          0: e = {2'b00, legacyPortSleeping[p], superspeedPortSleeping[p], 2'b00,
            legacyAttachSeen[p], superspeedAttachSeen[p]};
          1: e = {7'h00, portPowerOn[p]};
          default: e = {6'h00, minusLineHigh[p], plusLineHigh[p]};
        endcase
        chk("port byte", got[2 + p], e);
      end
    end
    $display("test ports done");
  endtask : test_ports

  task automatic test_info();
    logic [7:0] e;
    for (int c = 1; c < 4; c++) begin
      run({8'(c), 8'h00, 8'hEE});
      fetch(8'h01, 2);
      e = (c == 1) ? 8'h2D : (c == 2) ? {hubConfigured, legacyHubDeviceNumber} : chargerPortMask;
      chk("info status", got[0], HC_STAT_OK);
      chk("info byte", got[1], e);
    end
    $display("test info done");
  endtask : test_info

  task automatic test_kill();
    chk("kill reset", {1'b0, portPowerForcedOff, superspeedTerminationOff,
      legacyTerminationOff}, 16'h0000);
    run({HC_CMD_KILL, 8'h00, 8'h1F, 8'h85, 8'h07, 8'h82, 8'h80, 8'h87});
    chk("power off", portPowerForcedOff, 5'h11);
    chk("ss term", superspeedTerminationOff, 5'h14);
    chk("legacy term", legacyTerminationOff, 5'h11);
    // masked-out ports must keep what they had
    run({HC_CMD_KILL, 8'h00, 8'h01, 8'h80});
    chk("power off mask", portPowerForcedOff, 5'h10);
    chk("ss term mask", superspeedTerminationOff, 5'h14);
    chk("legacy term mask", legacyTerminationOff, 5'h10);
    $display("test kill done");
  endtask : test_kill

  task automatic test_charger();
    run({HC_CMD_CHGRD, 8'h00, 8'h10, 8'h00});
    fetch(8'h03, 1);
    chk("charger read", got[0], 8'h10 ^ 8'h5A);
    run({HC_CMD_CHGWR, 8'h00, 8'h20, 8'hC3});
    chk("charger write", lastWrite, 16'h20C3);
    run({HC_CMD_CHGBLK, 8'h00, 8'h30, 8'h04});
    fetch(8'h04, 4);
    for (int k = 0; k < 4; k++) begin
      chk("charger block", got[k], (8'h30 + 8'(k)) ^ 8'h5A);
    end
    $display("test charger done");
  endtask : test_charger

  task automatic test_misc();
    logic [7:0] counts[3] = '{8'h00, 8'h21, 8'h20};
    run({8'h87, 8'h00, 8'hA5});
    fetch(8'h01, 2);
    chk("unknown status", got[0], HC_STAT_BAD);
    chk("unknown data", got[1], 8'hA5);
    fetch(8'h83, 3);
    chk("tail ack", ack, 1'b1);
    foreach (got[k]) chk("tail data", got[k], 8'h00);
    foreach (counts[k]) begin
      op(HC_OP_START, {addr, 1'b0});
      op(HC_OP_WRITE, 8'h00);
      op(HC_OP_WRITE, 8'h00);
      op(HC_OP_WRITE, counts[k]);
      chk("count ack", ack, k == 2);
      op(HC_OP_READ, 8'h00);
      chk("read in write", ack, 1'b0);
      op(HC_OP_STOP, 8'h00);
    end
    // trigger with a wrong terminator must be refused
    op(HC_OP_START, {addr, 1'b0});
    op(HC_OP_WRITE, HC_TRIG_HI);
    op(HC_OP_WRITE, HC_TRIG_LO);
    op(HC_OP_WRITE, 8'h01);
    chk("bad end", ack, 1'b0);
    op(HC_OP_STOP, 8'h00);
    $display("test misc done");
  endtask : test_misc

  task automatic test_addr();
    run({HC_CMD_SETADDR, 8'h00, 8'h33});
    op(HC_OP_START, {addr, 1'b0});
    chk("old addr", ack, 1'b0);
    op(HC_OP_STOP, 8'h00);
    addr = 7'h33;
    run({HC_CMD_SETADDR, 8'h00, 8'h80});
    addr = HC_DEFAULT_ADDR;
    fetch(8'h01, 1);
    chk("restored status", got[0], HC_STAT_OK);
    $display("test addr done");
  endtask : test_addr

  initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    test_ports();
    test_info();
    test_kill();
    test_charger();
    test_misc();
    test_addr();
    conclude();
  end
endmodule : tb_top
`default_nettype wire
